/* File: design/time_base_regs.svh */
// register indices, field positions, reset values and timing figures of the time base
`ifndef TIME_BASE_REGS_SVH
`define TIME_BASE_REGS_SVH

// register indices; byte address is four times the index
`define TB_TAP_REG_IDX 8'h0F
`define TB_IRQ_STATUS_IDX 8'h10
`define TB_IRQ_ENABLE_IDX 8'h11
`define TB_MASTER_IDX 8'h12

// interrupt source bit positions in status and enable registers
`define TB_SRC_256HZ 0
`define TB_SRC_32HZ 1
`define TB_SRC_16HZ 2
`define TB_SRC_1HZ 3
`define TB_SRC_0P1HZ 4
`define TB_SRC_COUNT 5

// chain stage positions (bit k toggles at 32768 / 2**(k+1) Hz)
`define TB_BIT_256HZ 6
`define TB_BIT_128HZ 7
`define TB_BIT_64HZ 8
`define TB_BIT_32HZ 9
`define TB_BIT_16HZ 10
`define TB_BIT_8HZ 11
`define TB_BIT_4HZ 12
`define TB_BIT_2HZ 13
`define TB_BIT_1HZ 14
`define TB_LOW_FIRST 11

// reset values
`define TB_CHAIN_RESET 15'h0000
`define TB_DECADE_RESET 4'h0
`define TB_ENABLE_RESET 5'h00
`define TB_MASTER_RESET 1'h0

// timing
`define TB_CLK_HZ 32768
`define TB_BINARY_STAGES 15
`define TB_DECADE_DIV 10
`define TB_DECADE_HIGH_FROM 4'h5

`endif

/* File: design/time_base_pkg.sv */
// types shared by the time base divider chain and its users
package time_base_pkg;

   // fixed-frequency taps handed to the on-chip peripherals
   typedef struct packed {
      logic wdt_count_16hz;
      logic buzzer_1hz;
      logic buzzer_8hz;
      logic buzzer_16hz;
      logic port_sample_64hz;
      logic sysreset_1hz;
      logic sysreset_8hz;
      logic [3:0] capture_data;
   } tap_bundle_t;

   // apb request from the bus master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // apb answer back to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

/* File: design/time_base_divider_chain.sv */
// time base divider chain with apb registers and time base interrupts
`timescale 1ns/10ps
`default_nettype none
`include "time_base_regs.svh"

module time_base_divider_chain #(
   parameter int BINARY_STAGES = `TB_BINARY_STAGES,
   parameter int DECADE_DIV = `TB_DECADE_DIV
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tb_clk,
   input wire time_base_pkg::apb_req_t apb_req,
   output var time_base_pkg::apb_rsp_t apb_rsp,
   input wire logic irq_entry,
   input wire logic irq_return,
   output var time_base_pkg::tap_bundle_t taps,
   output logic [`TB_SRC_COUNT-1:0] tb_irq_req,
   output logic irq
);

   initial begin
      if (BINARY_STAGES != `TB_BINARY_STAGES || DECADE_DIV != `TB_DECADE_DIV) begin
         $error("time base chain only serves 15 binary stages and a divide by ten");
      end
      if (`TB_BIT_1HZ != BINARY_STAGES - 1) begin
         $error("1 Hz tap must be the last binary stage");
      end
      if (`TB_LOW_FIRST != `TB_BIT_8HZ || `TB_BIT_1HZ - `TB_LOW_FIRST != 3) begin
         $error("tap register needs four slow stages from 8 Hz up");
      end
      if (`TB_SRC_COUNT != 5) begin
         $error("five time base sources are decoded");
      end
      if (`TB_DECADE_HIGH_FROM != DECADE_DIV / 2) begin
         $error("decade output must be high for its upper half");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode

   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [14:0] chain_ff;
   logic [3:0] decade_ff;
   logic [`TB_SRC_COUNT-1:0] status_ff;
   logic [`TB_SRC_COUNT-1:0] enable_ff;
   logic master_ff;
   logic tb_clk_ff;
   logic [`TB_SRC_COUNT-1:0] src_prev_ff;
   logic [`TB_SRC_COUNT-1:0] rd_snap_ff;
   logic [`TB_SRC_COUNT-1:0] req_ff;
   logic irq_ff;
   time_base_pkg::tap_bundle_t taps_ff;

   wire [9:0] reg_idx;
   wire hit_tap;
   wire hit_status;
   wire hit_enable;
   wire hit_master;
   wire hit_any;
   wire acc_first;
   wire acc_done;
   wire wr_done;
   wire rd_done;
   wire tap_write;

   assign reg_idx = apb_req.paddr[11:2];
   assign hit_tap = reg_idx == {2'h0, `TB_TAP_REG_IDX};
   assign hit_status = reg_idx == {2'h0, `TB_IRQ_STATUS_IDX};
   assign hit_enable = reg_idx == {2'h0, `TB_IRQ_ENABLE_IDX};
   assign hit_master = reg_idx == {2'h0, `TB_MASTER_IDX};
   assign hit_any = hit_tap | hit_status | hit_enable | hit_master;
   // first access cycle: prepare answer; second: complete
   assign acc_first = apb_req.psel & apb_req.penable & ~pready_ff;
   assign acc_done = apb_req.psel & apb_req.penable & pready_ff;
   assign wr_done = acc_done & apb_req.pwrite & ~pslverr_ff;
   assign rd_done = acc_done & ~apb_req.pwrite & ~pslverr_ff;
   assign tap_write = wr_done & hit_tap;

   // read words; unused upper bits read as zero
   wire [31:0] rd_tap_word = {28'h0000000, chain_ff[`TB_BIT_1HZ:`TB_LOW_FIRST]};
   wire [31:0] rd_status_word = {27'h0000000, status_ff};
   wire [31:0] rd_enable_word = {27'h0000000, enable_ff};
   wire [31:0] rd_master_word = {31'h00000000, master_ff};
   wire [31:0] rd_mux =
      hit_tap ? rd_tap_word :
      hit_status ? rd_status_word :
      hit_enable ? rd_enable_word :
      hit_master ? rd_master_word : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // divider chain

   wire tb_fall = tb_clk_ff & ~tb_clk;
   wire [14:0] chain_inc = chain_ff + 15'h0001;
   wire [14:0] chain_adv = tb_fall ? chain_inc : chain_ff;
   wire one_hz_fall = chain_ff[`TB_BIT_1HZ] & ~chain_adv[`TB_BIT_1HZ];
   wire [3:0] decade_adv =
      ~one_hz_fall ? decade_ff :
      (decade_ff == 4'(DECADE_DIV - 1)) ? 4'h0 : decade_ff + 4'h1;
   wire [14:0] low_clear_mask = 15'h07FF;
   // a write clears the slow stages and the decade counter; fast stages keep counting
   wire [14:0] nxt_chain = tap_write ? (chain_adv & low_clear_mask) : chain_adv;
   wire [3:0] nxt_decade = tap_write ? 4'h0 : decade_adv;
   wire tenth_hz = decade_ff >= `TB_DECADE_HIGH_FROM;

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt sources

   wire src_256hz = chain_ff[`TB_BIT_256HZ];
   wire src_32hz = chain_ff[`TB_BIT_32HZ];
   wire src_16hz = chain_ff[`TB_BIT_16HZ];
   wire src_1hz = chain_ff[`TB_BIT_1HZ];
   wire src_tenth = tenth_hz;
   wire [`TB_SRC_COUNT-1:0] src_now =
      {src_tenth, src_1hz, src_16hz, src_32hz, src_256hz};
   // a write clear looks like any other fall, so it requests too
   wire [`TB_SRC_COUNT-1:0] src_fall = src_prev_ff & ~src_now;
   wire [`TB_SRC_COUNT-1:0] rd_clear =
      (rd_done & hit_status) ? rd_snap_ff : {`TB_SRC_COUNT{1'b0}};
   // set wins over the read clear; only bits that were reported get cleared
   wire [`TB_SRC_COUNT-1:0] nxt_status = (status_ff & ~rd_clear) | src_fall;
   wire [`TB_SRC_COUNT-1:0] nxt_enable =
      (wr_done & hit_enable) ? apb_req.pwdata[`TB_SRC_COUNT-1:0] : enable_ff;
   wire nxt_master =
      irq_entry ? 1'b0 :
      irq_return ? 1'b1 :
      (wr_done & hit_master) ? apb_req.pwdata[0] : master_ff;
   wire nxt_irq = master_ff & |(status_ff & enable_ff);

   time_base_pkg::tap_bundle_t nxt_taps;
   always_comb begin
      nxt_taps.wdt_count_16hz = nxt_chain[`TB_BIT_16HZ];
      nxt_taps.buzzer_1hz = nxt_chain[`TB_BIT_1HZ];
      nxt_taps.buzzer_8hz = nxt_chain[`TB_BIT_8HZ];
      nxt_taps.buzzer_16hz = nxt_chain[`TB_BIT_16HZ];
      nxt_taps.port_sample_64hz = nxt_chain[`TB_BIT_64HZ];
      nxt_taps.sysreset_1hz = nxt_chain[`TB_BIT_1HZ];
      nxt_taps.sysreset_8hz = nxt_chain[`TB_BIT_8HZ];
      nxt_taps.capture_data = nxt_chain[`TB_BIT_32HZ:`TB_BIT_256HZ];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // answer and edge history next values

   // answer is prepared in the first access cycle, so every transfer has one wait state
   wire nxt_pready = acc_first;
   wire nxt_pslverr = acc_first & ~hit_any;
   wire [31:0] nxt_prdata = (acc_first & ~apb_req.pwrite) ? rd_mux : 32'h00000000;
   // snapshot keeps a set landing between answer and completion from being lost
   wire [`TB_SRC_COUNT-1:0] nxt_rd_snap = acc_first ? status_ff : rd_snap_ff;
   wire nxt_tb_clk = tb_clk;
   wire [`TB_SRC_COUNT-1:0] nxt_src_prev = src_now;
   wire [`TB_SRC_COUNT-1:0] nxt_req = src_fall;

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         chain_ff <= `TB_CHAIN_RESET;
      end else begin
         chain_ff <= nxt_chain;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         decade_ff <= `TB_DECADE_RESET;
      end else begin
         decade_ff <= nxt_decade;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tb_clk_ff <= 1'b0;
      end else begin
         tb_clk_ff <= nxt_tb_clk;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         src_prev_ff <= {`TB_SRC_COUNT{1'b0}};
      end else begin
         src_prev_ff <= nxt_src_prev;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         taps_ff <= '0;
      end else begin
         taps_ff <= nxt_taps;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         status_ff <= {`TB_SRC_COUNT{1'b0}};
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         enable_ff <= `TB_ENABLE_RESET;
      end else begin
         enable_ff <= nxt_enable;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         master_ff <= `TB_MASTER_RESET;
      end else begin
         master_ff <= nxt_master;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         req_ff <= {`TB_SRC_COUNT{1'b0}};
      end else begin
         req_ff <= nxt_req;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prdata_ff <= 32'h00000000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rd_snap_ff <= {`TB_SRC_COUNT{1'b0}};
      end else begin
         rd_snap_ff <= nxt_rd_snap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign apb_rsp.pready = pready_ff;
   assign apb_rsp.pslverr = pslverr_ff;
   assign apb_rsp.prdata = prdata_ff;
   assign taps = taps_ff;
   assign tb_irq_req = req_ff;
   assign irq = irq_ff;

endmodule
`default_nettype wire

/* File: verif/tb_chain_properties.sv */
// port assertions for the time base divider chain
`timescale 1ns/10ps
`default_nettype none
`include "time_base_regs.svh"
module tb_chain_props #(parameter int BINARY_STAGES = 15, parameter int DECADE_DIV = 10) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tb_clk,
   input wire time_base_pkg::apb_req_t apb_req,
   input wire time_base_pkg::apb_rsp_t apb_rsp,
   input wire logic irq_entry,
   input wire logic irq_return,
   input wire time_base_pkg::tap_bundle_t taps,
   input wire logic [`TB_SRC_COUNT-1:0] tb_irq_req,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   chk_reset_clears: assert property (disable iff (1'h0) !nrst |=> taps == '0)
      else $error("taps not cleared by reset");
   chk_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   chk_pready_wait: assert property (apb_rsp.pready |-> $past(apb_req.penable) && apb_req.penable)
      else $error("pready without one wait state");
   chk_unmapped_error: assert property (apb_rsp.pready |->
      apb_rsp.pslverr == !(apb_req.paddr[11:2] inside {[10'h00F:10'h012]}))
      else $error("pslverr wrong for address");
   chk_wdt_tap: assert property ($changed(taps.wdt_count_16hz) |->
      $past(taps.capture_data) == 4'hF && taps.capture_data == 4'h0)
      else $error("watchdog tap moved without a carry");
   chk_sysreset_taps: assert property (taps.sysreset_1hz == taps.buzzer_1hz
      && taps.sysreset_8hz == taps.buzzer_8hz) else $error("system reset taps differ");
   chk_capture_falls: assert property ($changed(taps.capture_data) |->
      $past(tb_clk, 2) && !$past(tb_clk)) else $error("chain moved without clock fall");
   chk_fall_request: assert property ($fell(taps.wdt_count_16hz) |->
      ##[0:2] tb_irq_req[`TB_SRC_16HZ]) else $error("no 16 Hz request on fall");
   chk_entry_masks: assert property (irq_entry |-> ##2 !irq)
      else $error("irq stays high after entry");
endmodule
bind time_base_divider_chain tb_chain_props #(.BINARY_STAGES(BINARY_STAGES),
   .DECADE_DIV(DECADE_DIV)) chk_u (.mclk, .nrst, .tb_clk, .apb_req, .apb_rsp,
   .irq_entry, .irq_return, .taps, .tb_irq_req, .irq);
`default_nettype wire

/* File: verif/irq_host_model.sv */
// interrupt controller stand-in: enters when serve rises while irq is high, returns when serve drops
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (
   input wire logic mclk,
   input wire logic irq,
   input wire logic serve,
   output logic irq_entry = 1'h0,
   output logic irq_return = 1'h0
);
   logic serve_ff = 1'h0;
   always @(posedge mclk) begin
      serve_ff <= serve;
      irq_entry <= serve && !serve_ff && irq;
      irq_return <= serve_ff && !serve;
   end
endmodule
`default_nettype wire

/* File: verif/time_base_divider_chain_test.sv */
// self-checking bench for the time base divider chain
`timescale 1ns/10ps
`default_nettype none
`include "time_base_regs.svh"
module time_base_divider_chain_test;
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   logic tb_clk = 1'h0;
   logic serve = 1'h0;
   logic irq_entry, irq_return, irq;
   logic [`TB_SRC_COUNT-1:0] tb_irq_req;
   time_base_pkg::apb_req_t apb_req = '0;
   time_base_pkg::apb_rsp_t apb_rsp;
   time_base_pkg::tap_bundle_t taps;
   int miscompares = 0;
   int n_tests = 0;
   int n_req1hz = 0;
   logic [14:0] cnt = 15'h0000;
   logic [14:0] old;
   logic [31:0] rd;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) if (tb_irq_req[`TB_SRC_1HZ] === 1'h1) n_req1hz++;
   time_base_divider_chain dut_u (.mclk(mclk), .nrst(nrst), .tb_clk(tb_clk), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .irq_entry(irq_entry), .irq_return(irq_return), .taps(taps),
      .tb_irq_req(tb_irq_req), .irq(irq));
   irq_host_model host_u (.mclk(mclk), .irq(irq), .serve(serve), .irq_entry(irq_entry),
      .irq_return(irq_return));
   ////////////////////////////////////////////////////////////
   function automatic time_base_pkg::tap_bundle_t exp_taps(input logic [14:0] c);
      return '{c[10], c[14], c[11], c[10], c[8], c[14], c[11], c[9:6]};
   endfunction
   // a stage k fell when the count crossed a multiple of 2**(k+1)
   function automatic logic [31:0] exp_status(input logic [14:0] a, input logic [14:0] b);
      return {27'h0, 1'h0, a[14] != b[14], a[14:11] != b[14:11], a[14:10] != b[14:10],
         a[14:7] != b[14:7]};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic err);
      apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: wd};
      @(posedge mclk);
      apb_req.penable <= 1'h1;
      do @(posedge mclk); while (apb_rsp.pready !== 1'h1);
      rd = apb_rsp.prdata;
      check("pslverr", {31'h0, err}, {31'h0, apb_rsp.pslverr});
      apb_req <= '0;
      @(posedge mclk);
   endtask
   task automatic run(input int n);
      repeat (n) begin
         tb_clk <= 1'h1;
         repeat (2 + $urandom % 2) @(posedge mclk);
         tb_clk <= 1'h0;
         repeat (2) @(posedge mclk);
         cnt++;
      end
      repeat (4) @(posedge mclk);
   endtask
   task automatic results;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hCDAF));
      repeat (10) @(posedge mclk);
      nrst <= 1'h1;
      @(posedge mclk);
      apb(1'h0, `TB_TAP_REG_IDX, 32'h0, 1'h0);
      check("tap reset", 32'h0, rd);
      apb(1'h0, `TB_IRQ_ENABLE_IDX, 32'h0, 1'h0);
      check("enable reset", 32'h0, rd);
      apb(1'h0, 8'h20, 32'h0, 1'h1);
      $display("test reset values done");
      run(16384 + $urandom % 300);
      check("taps", 32'(exp_taps(cnt)), 32'(taps));
      apb(1'h0, `TB_TAP_REG_IDX, 32'h0, 1'h0);
      check("tap read", {28'h0, cnt[14:11]}, rd);
      apb(1'h1, `TB_IRQ_ENABLE_IDX, 32'h1F, 1'h0);
      apb(1'h1, `TB_MASTER_IDX, 32'h1, 1'h0);
      apb(1'h0, `TB_IRQ_STATUS_IDX, 32'h0, 1'h0);
      apb(1'h1, `TB_TAP_REG_IDX, $urandom, 1'h0);
      cnt[14:11] = 4'h0;
      repeat (4) @(posedge mclk);
      check("taps cleared", 32'(exp_taps(cnt)), 32'(taps));
      check("irq on clear", 32'h1, {31'h0, irq});
      check("1 Hz requests", 32'h1, n_req1hz);
      serve <= 1'h1;
      repeat (4) @(posedge mclk);
      check("irq in entry", 32'h0, {31'h0, irq});
      serve <= 1'h0;
      repeat (4) @(posedge mclk);
      check("irq on return", 32'h1, {31'h0, irq});
      apb(1'h0, `TB_IRQ_STATUS_IDX, 32'h0, 1'h0);
      check("status", 32'h8, rd);
      $display("test tap clear done");
      apb(1'h1, `TB_IRQ_ENABLE_IDX, 32'h0, 1'h0);
      old = cnt;
      run(128);
      check("irq masked", 32'h0, {31'h0, irq});
      apb(1'h0, `TB_IRQ_STATUS_IDX, 32'h0, 1'h0);
      check("masked status", exp_status(old, cnt), rd);
      apb(1'h1, `TB_MASTER_IDX, 32'h0, 1'h0);
      apb(1'h1, `TB_TAP_REG_IDX, $urandom, 1'h0);
      apb(1'h0, `TB_IRQ_STATUS_IDX, 32'h0, 1'h0);
      repeat (4) @(posedge mclk);
      check("irq quiet write", 32'h0, {31'h0, irq});
      nrst <= 1'h0;
      repeat (2) @(posedge mclk);
      nrst <= 1'h1;
      @(posedge mclk);
      check("taps after reset", 32'h0, 32'(taps));
      $display("test masking and reset done");
      results();
   end
   initial begin
      #480000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
